/* hw/tx_frame_pkg.sv */
// Contract
// - Send only final_byte_bit_count bits; zero sends all
// - LSB first; truncation drops the top bits
// - Grid align: start spacing whole ETUs
// - Payload select clear sends one symbol pattern
// - Burst code maps to 8..128 bits
// - Burst is unmodulated subcarrier at chosen level
// - Guard origin: end of TX or RX
// - Guard unit: 16 clocks or half bit
// - Guard count is eleven bits, upper in 5:3
// - Hold new transmission until guard elapsed
// - Stop/guard select encodes stop bit and EGTs
// - Guard control resets to c0
package tx_frame_pkg;
    localparam logic [7:0] IDX_FRAME_CTRL  = 8'h2e; // Register indexes
    localparam logic [7:0] IDX_BURST_LEN   = 8'h30;
    localparam logic [7:0] IDX_GUARD_CTRL  = 8'h31;
    localparam logic [7:0] IDX_GUARD_LOW   = 8'h32;
    localparam logic [7:0] ADDR_FRAME_CTRL = {IDX_FRAME_CTRL[5:0], 2'b00}; // Index times four
    localparam logic [7:0] ADDR_BURST_LEN  = {IDX_BURST_LEN[5:0], 2'b00};
    localparam logic [7:0] ADDR_GUARD_CTRL = {IDX_GUARD_CTRL[5:0], 2'b00};
    localparam logic [7:0] ADDR_GUARD_LOW  = {IDX_GUARD_LOW[5:0], 2'b00};
    localparam logic [7:0] ADDR_STATUS     = 8'hcc; // Block status
    localparam logic [7:0] MASK_FRAME_CTRL = 8'h1f;
    localparam logic [7:0] MASK_BURST_LEN  = 8'h70;
    localparam logic [7:0] MASK_GUARD_CTRL = 8'hff;
    localparam logic [7:0] RST_FRAME_CTRL  = 8'h00;
    localparam logic [7:0] RST_BURST_LEN   = 8'h00;
    localparam logic [7:0] RST_GUARD_CTRL  = 8'hc0;
    localparam logic [7:0] RST_GUARD_LOW   = 8'h00;
    localparam int BIT_ETU_EN   = 4;
    localparam int BIT_PAYLOAD  = 3;
    localparam int BIT_ORIGIN   = 7;
    localparam int BIT_UNIT     = 6;
    localparam int CLK_PER_FC16 = 236; // 16 cycles of 13.56 MHz at 200 MHz, rounded
    localparam logic [1:0] RESP_OKAY   = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage

/* hw/guard_timer.sv */
`timescale 1ns/1ps
`default_nettype none
// Counts guard units after a start pulse; done is a level
module guard_timer (
    input  wire logic        ref_clk,
    input  wire logic        srst,
    input  wire logic        start,
    input  wire logic [10:0] count,
    input  wire logic [15:0] unit_clks,
    output logic             done
);
    logic [10:0] units_r;
    logic [15:0] sub_r;
    wire unit_tick = (sub_r == 16'h0000);
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            units_r <= 11'h000;
            sub_r   <= 16'h0000;
            done    <= 1'b1;
        end else if (start) begin
            units_r <= count;
            sub_r   <= unit_clks;
            done    <= (count == 11'h000);
        end else if (!done) begin
            sub_r <= unit_tick ? unit_clks : sub_r - 16'h0001;
            if (unit_tick) begin
                units_r <= units_r - 11'h001;
                done    <= (units_r == 11'h001);
            end
        end
    end
endmodule
`default_nettype wire

/* hw/tx_frame_timing_config.sv */
`timescale 1ns/1ps
`default_nettype none
module tx_frame_timing_config #(
    parameter int BIT_CLKS = 1884 // ref_clk cycles per bit, about 106 kbit/s
) (
    input  wire logic        ref_clk,
    input  wire logic        srst,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic        tx_start,
    input  wire logic        burst_req,
    input  wire logic        burst_level_control,
    input  wire logic        rx_end,
    input  wire logic [7:0]  tx_byte,
    input  wire logic        tx_byte_last,
    output logic             tx_byte_take,
    output logic             tx_bit,
    output logic             tx_active,
    output logic             tx_done
);
    import tx_frame_pkg::*;

    typedef enum logic [4:0] {
        ST_IDLE  = 5'b00001,
        ST_WAIT  = 5'b00010,
        ST_DATA  = 5'b00100,
        ST_BURST = 5'b01000,
        ST_STOP  = 5'b10000
    } tx_state_e;

    logic [7:0]  frame_ctrl_r, burst_len_r, guard_ctrl_r, guard_low_r;
    logic        aw_got_r, w_got_r;
    logic [7:0]  awaddr_r;
    logic [31:0] wdata_r;
    logic [3:0]  wstrb_r;
    tx_state_e   state_r;
    logic [7:0]  shreg_r;
    logic [3:0]  bits_left_r;
    logic        last_r;
    logic [7:0]  burst_left_r;
    logic [3:0]  stop_left_r;
    logic [15:0] bit_cnt_r;
    logic [15:0] etu_phase_r;
    logic        guard_start_r;

    // Register decode and write-data merge
    wire        do_write   = aw_got_r && w_got_r && !s_axi_bvalid;
    wire        hit_fc     = (awaddr_r == ADDR_FRAME_CTRL);
    wire        hit_bl     = (awaddr_r == ADDR_BURST_LEN);
    wire        hit_gc     = (awaddr_r == ADDR_GUARD_CTRL);
    wire        hit_gl     = (awaddr_r == ADDR_GUARD_LOW);
    wire        wr_hit     = hit_fc | hit_bl | hit_gc | hit_gl;
    wire        wr_lane0   = do_write && wstrb_r[0];
    wire [7:0]  wbyte      = wdata_r[7:0];
    wire        rd_fc      = (s_axi_araddr == ADDR_FRAME_CTRL);
    wire        rd_bl      = (s_axi_araddr == ADDR_BURST_LEN);
    wire        rd_gc      = (s_axi_araddr == ADDR_GUARD_CTRL);
    wire        rd_gl      = (s_axi_araddr == ADDR_GUARD_LOW);
    wire        rd_st      = (s_axi_araddr == ADDR_STATUS);
    wire        rd_hit     = rd_fc | rd_bl | rd_gc | rd_gl | rd_st;
    wire [7:0]  status     = {3'b000, state_r};
    wire [7:0]  rd_byte    = rd_fc ? frame_ctrl_r : rd_bl ? burst_len_r :
                             rd_gc ? guard_ctrl_r : rd_gl ? guard_low_r :
                             rd_st ? status : 8'h00;

    // Configuration fields
    wire [2:0]  last_bits  = frame_ctrl_r[2:0];
    wire        payload_en = frame_ctrl_r[BIT_PAYLOAD];
    wire        etu_align  = frame_ctrl_r[BIT_ETU_EN];
    wire [2:0]  burst_code = burst_len_r[6:4];
    wire        origin_rx  = guard_ctrl_r[BIT_ORIGIN];
    wire        unit_bit   = guard_ctrl_r[BIT_UNIT];
    wire [10:0] guard_cnt  = {guard_ctrl_r[5:3], guard_low_r};
    wire [2:0]  stop_sel   = guard_ctrl_r[2:0];
    wire [15:0] unit_clks  = unit_bit ? 16'((BIT_CLKS / 2) - 1)
                                      : 16'(CLK_PER_FC16 - 1);
    wire        guard_done;

    // Burst length table; unused code 3 gives the shortest burst
    logic [7:0] burst_bits;
    always_comb begin
        case (burst_code)
            3'd0:    burst_bits = 8'd8;
            3'd1:    burst_bits = 8'd16;
            3'd2:    burst_bits = 8'd32;
            3'd4:    burst_bits = 8'd48;
            3'd5:    burst_bits = 8'd64;
            3'd6:    burst_bits = 8'd96;
            3'd7:    burst_bits = 8'd128;
            default: burst_bits = 8'd8;
        endcase
    end

    // Bits in the byte being loaded
    wire [3:0]  load_bits  = (tx_byte_last && last_bits != 3'd0) ?
                             {1'b0, last_bits} : 4'd8;
    wire        bit_end    = (bit_cnt_r == 16'(BIT_CLKS - 1));
    wire        on_grid    = (etu_phase_r == 16'h0000);
    wire        may_start  = guard_done && (!etu_align || on_grid);
    wire        go         = (state_r == ST_WAIT) && may_start;
    wire        frame_end  = (state_r == ST_STOP && (stop_left_r == 4'd0 || bit_end))
                             && stop_left_r <= 4'd1 ||
                             (state_r == ST_BURST && bit_end && burst_left_r == 8'd1) ||
                             (state_r == ST_DATA && bit_end && bits_left_r == 4'd1
                              && last_r && stop_sel == 3'd0);
    wire [3:0]  stop_len   = (stop_sel == 3'd0) ? 4'd0 : {1'b0, stop_sel};

    // AXI write channel capture
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            aw_got_r <= 1'b0;
            w_got_r  <= 1'b0;
            awaddr_r <= 8'h00;
            wdata_r  <= 32'h0000_0000;
            wstrb_r  <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_got_r <= 1'b1;
                awaddr_r <= s_axi_awaddr;
            end else if (s_axi_bvalid && s_axi_bready) begin
                aw_got_r <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_got_r <= 1'b1;
                wdata_r <= s_axi_wdata;
                wstrb_r <= s_axi_wstrb;
            end else if (s_axi_bvalid && s_axi_bready) begin
                w_got_r <= 1'b0;
            end
        end
    end

    // AXI handshakes and responses
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= RESP_OKAY;
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= RESP_OKAY;
        end else begin
            s_axi_awready <= !aw_got_r && !(s_axi_awvalid && s_axi_awready);
            s_axi_wready  <= !w_got_r && !(s_axi_wvalid && s_axi_wready);
            if (do_write) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
            s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= {24'h000000, rd_byte};
                s_axi_rresp  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // Configuration registers; reserved bits masked off
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            frame_ctrl_r <= RST_FRAME_CTRL;
            burst_len_r  <= RST_BURST_LEN;
            guard_ctrl_r <= RST_GUARD_CTRL;
            guard_low_r  <= RST_GUARD_LOW;
        end else if (wr_lane0) begin
            if (hit_fc) frame_ctrl_r <= wbyte & MASK_FRAME_CTRL;
            if (hit_bl) burst_len_r  <= wbyte & MASK_BURST_LEN;
            if (hit_gc) guard_ctrl_r <= wbyte & MASK_GUARD_CTRL;
            if (hit_gl) guard_low_r  <= wbyte;
        end
    end

    // Bit clock and ETU grid phase
    always_ff @(posedge ref_clk) begin
        if (srst || go) begin
            bit_cnt_r <= 16'h0000;
        end else begin
            bit_cnt_r <= bit_end ? 16'h0000 : bit_cnt_r + 16'h0001;
        end
    end
    always_ff @(posedge ref_clk) begin
        if (srst || go) begin
            etu_phase_r <= 16'h0001; // Grid anchored at each start
        end else begin
            etu_phase_r <= (etu_phase_r == 16'(BIT_CLKS - 1)) ? 16'h0000
                                                                : etu_phase_r + 16'h0001;
        end
    end

    // Guard reference point select
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            guard_start_r <= 1'b0;
        end else begin
            guard_start_r <= origin_rx ? rx_end : frame_end;
        end
    end

    guard_timer u_guard (
        .ref_clk   (ref_clk),
        .srst      (srst),
        .start     (guard_start_r),
        .count     (guard_cnt),
        .unit_clks (unit_clks),
        .done      (guard_done)
    );

    // Transmit sequencer
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            state_r      <= ST_IDLE;
            shreg_r      <= 8'h00;
            bits_left_r  <= 4'd0;
            last_r       <= 1'b0;
            burst_left_r <= 8'd0;
            stop_left_r  <= 4'd0;
            tx_bit       <= 1'b0;
            tx_active    <= 1'b0;
            tx_byte_take <= 1'b0;
            tx_done      <= 1'b0;
        end else begin
            tx_byte_take <= 1'b0;
            tx_done      <= frame_end;
            case (state_r)
                ST_IDLE: begin
                    if (tx_start || burst_req) begin
                        state_r      <= ST_WAIT;
                        burst_left_r <= burst_req ? burst_bits : 8'd0;
                    end
                end
                ST_WAIT: begin
                    if (may_start) begin
                        tx_active <= 1'b1;
                        if (burst_left_r != 8'd0) begin
                            state_r <= ST_BURST;
                            tx_bit  <= burst_level_control;
                        end else if (payload_en) begin
                            state_r      <= ST_DATA;
                            shreg_r      <= tx_byte;
                            bits_left_r  <= load_bits;
                            last_r       <= tx_byte_last;
                            tx_byte_take <= 1'b1;
                            tx_bit       <= tx_byte[0];
                        end else begin
                            state_r     <= ST_STOP; // One symbol pattern only
                            stop_left_r <= 4'd1;
                            tx_bit      <= 1'b0;
                        end
                    end
                end
                ST_BURST: begin
                    if (bit_end) begin
                        burst_left_r <= burst_left_r - 8'd1;
                        if (burst_left_r == 8'd1) begin
                            state_r   <= ST_IDLE;
                            tx_active <= 1'b0;
                        end
                    end
                end
                ST_DATA: begin
                    if (bit_end) begin
                        if (bits_left_r != 4'd1) begin
                            shreg_r     <= {1'b0, shreg_r[7:1]};
                            tx_bit      <= shreg_r[1];
                            bits_left_r <= bits_left_r - 4'd1;
                        end else if (!last_r) begin
                            shreg_r      <= tx_byte;
                            bits_left_r  <= load_bits;
                            last_r       <= tx_byte_last;
                            tx_byte_take <= 1'b1;
                            tx_bit       <= tx_byte[0];
                        end else if (stop_sel != 3'd0) begin
                            state_r     <= ST_STOP;
                            stop_left_r <= stop_len;
                            tx_bit      <= 1'b1;
                        end else begin
                            state_r   <= ST_IDLE;
                            tx_active <= 1'b0;
                        end
                    end
                end
                ST_STOP: begin
                    if (bit_end || stop_left_r == 4'd0) begin
                        stop_left_r <= stop_left_r - 4'd1;
                        if (stop_left_r <= 4'd1) begin
                            state_r   <= ST_IDLE;
                            tx_active <= 1'b0;
                            tx_bit    <= 1'b0;
                        end
                    end
                end
                default: state_r <= ST_IDLE;
            endcase
        end
    end

    a_guard_hold: assert property (@(posedge ref_clk) disable iff (srst)
        (state_r == ST_WAIT && !guard_done) |=> !tx_active)
        else $error("start during guard wait");
    a_grid_start: assert property (@(posedge ref_clk) disable iff (srst)
        (go && etu_align) |-> on_grid)
        else $error("start off the etu grid");
    a_reset_guard: assert property (@(posedge ref_clk)
        $fell(srst) |-> guard_ctrl_r == 8'hc0)
        else $error("guard control reset wrong");
    a_reserved_zero: assert property (@(posedge ref_clk) disable iff (srst)
        frame_ctrl_r[7:5] == 3'b000 && burst_len_r[7] == 1'b0
        && burst_len_r[3:0] == 4'h0)
        else $error("reserved bit set");
    a_guard_count: assert property (@(posedge ref_clk) disable iff (srst)
        guard_start_r |=> u_guard.units_r == $past(guard_cnt))
        else $error("guard count not loaded");
    a_unit_size: assert property (@(posedge ref_clk) disable iff (srst)
        !unit_bit |-> unit_clks == 16'd235)
        else $error("guard unit size wrong");
    a_origin_rx: assert property (@(posedge ref_clk) disable iff (srst)
        (origin_rx && rx_end) |=> guard_start_r)
        else $error("rx origin missed");
    a_lsb_first: assert property (@(posedge ref_clk) disable iff (srst)
        (go && payload_en && burst_left_r == 8'd0) |=> tx_bit == $past(tx_byte[0]))
        else $error("first bit not lsb");
    a_final_bits: assert property (@(posedge ref_clk) disable iff (srst)
        (go && payload_en && burst_left_r == 8'd0 && tx_byte_last && last_bits != 3'd0)
        |=> bits_left_r == {1'b0, $past(last_bits)})
        else $error("final byte bit count wrong");
    a_symbol_only: assert property (@(posedge ref_clk) disable iff (srst)
        (go && !payload_en && burst_left_r == 8'd0) |=> state_r == ST_STOP)
        else $error("data sent with payload off");
    a_burst_level: assert property (@(posedge ref_clk) disable iff (srst)
        state_r == ST_BURST |-> tx_bit == $past(burst_level_control, 1) || !$rose(tx_active))
        else $error("burst level wrong");

    c_data_frame: cover property (@(posedge ref_clk) state_r == ST_DATA ##1 state_r == ST_IDLE);
    c_burst: cover property (@(posedge ref_clk) state_r == ST_BURST);
    c_stop: cover property (@(posedge ref_clk) state_r == ST_STOP && stop_left_r > 4'd1);
endmodule
`default_nettype wire

/* sim/tag_model.sv */
`timescale 1ns/1ps
`default_nettype none
// Tag across the field: samples each bit mid-cell, times frame starts, replies on request
module tag_model #(
    parameter int BIT_CLKS = 8
) (
    input  wire logic ref_clk,
    input  wire logic srst,
    input  wire logic tx_bit,
    input  wire logic tx_active,
    input  wire logic tx_done,
    output logic      rx_end
);
    logic bit_q[$];
    logic act_prev;
    logic reply_en;
    int   cyc, ph, done_t, rxe_t, start_t, spacing, gap_tx, gap_rx, wait_n;
    int   reply_dly;

    initial begin
        rx_end = 1'b0;
        reply_en = 1'b0;
        reply_dly = 20;
        act_prev = 1'b0;
    end

    // Capture bits and record start spacing and gaps
    always @(posedge ref_clk) begin
        if (srst) begin
            act_prev = 1'b0;
        end else begin
            if (tx_active && !act_prev) begin
                spacing = cyc - start_t;
                start_t = cyc;
                gap_tx = cyc - done_t;
                gap_rx = cyc - rxe_t;
                ph = 0;
            end
            if (tx_active) begin
                if (ph % BIT_CLKS == BIT_CLKS / 2) bit_q.push_back(tx_bit);
                ph++;
            end
            if (tx_done) done_t = cyc;
            if (rx_end) rxe_t = cyc;
            act_prev = tx_active;
        end
        cyc++;
    end

    // Answer a frame with an end of reception after a delay
    always @(posedge ref_clk) begin
        rx_end <= (wait_n == 1);
        if (wait_n > 0) wait_n--;
        if (tx_done && reply_en) wait_n = reply_dly;
    end
endmodule
`default_nettype wire

/* sim/tx_frame_timing_config_tb.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin error_cnt++; \
    $display("ERROR %s exp %0h got %0h", nm, e, g); end end
module tx_frame_timing_config_tb;
    import tx_frame_pkg::*;
    localparam int BC = 8;
    logic        ref_clk, srst, tx_start, burst_req, burst_level_control, rx_end;
    logic [7:0]  s_axi_awaddr, s_axi_araddr, tx_byte;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp, wresp, rresp;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic        tx_byte_last, tx_byte_take, tx_bit, tx_active, tx_done;
    logic [7:0]  bytes [4] = '{8'ha5, 8'hb2, 8'h3c, 8'h81};
    logic [7:0]  addrs [4] = '{ADDR_FRAME_CTRL, ADDR_BURST_LEN, ADDR_GUARD_CTRL, ADDR_GUARD_LOW};
    logic [7:0]  rstv [4]  = '{8'h00, 8'h00, 8'hc0, 8'h00};
    logic [7:0]  maskv [4] = '{8'h1f, 8'h70, 8'hff, 8'hff};
    int          codes [7] = '{0, 1, 2, 4, 5, 6, 7};
    int          lens [7]  = '{8, 16, 32, 48, 64, 96, 128};
    int          error_cnt, cmp_count, bidx, nbytes, nbits;
    logic        all_lvl;

    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end

    tx_frame_timing_config #(.BIT_CLKS(BC)) dut (.ref_clk(ref_clk), .srst(srst),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .tx_start(tx_start),
        .burst_req(burst_req), .burst_level_control(burst_level_control), .rx_end(rx_end),
        .tx_byte(tx_byte), .tx_byte_last(tx_byte_last), .tx_byte_take(tx_byte_take),
        .tx_bit(tx_bit), .tx_active(tx_active), .tx_done(tx_done));

    tag_model #(.BIT_CLKS(BC)) tag (.ref_clk(ref_clk), .srst(srst), .tx_bit(tx_bit),
        .tx_active(tx_active), .tx_done(tx_done), .rx_end(rx_end));

    // Payload source: next byte advances on each take
    always @(posedge ref_clk) begin
        if (tx_start) bidx <= 0;
        else if (tx_byte_take) bidx <= bidx + 1;
    end
    assign tx_byte = bytes[bidx[1:0]];
    assign tx_byte_last = (bidx >= nbytes - 1);

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge ref_clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        wresp = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask

    task automatic rdr(input logic [7:0] a);
        @(posedge ref_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge ref_clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        rd = s_axi_rdata;
        rresp = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask

    // One frame or burst, waited out to its end
    task automatic frame(input int nb, input logic burst);
        nbytes = nb;
        tag.bit_q.delete();
        @(posedge ref_clk);
        if (burst) burst_req <= 1'b1;
        else tx_start <= 1'b1;
        @(posedge ref_clk);
        burst_req <= 1'b0;
        tx_start <= 1'b0;
        do @(posedge ref_clk); while (tx_done !== 1'b1);
    endtask

    task automatic finish_test();
        $display("Comparisons %0d, mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // Watchdog against a hung handshake or frame
    initial begin
        repeat (80000) @(posedge ref_clk);
        error_cnt++;
        finish_test();
    end

    initial begin
        {tx_start, burst_req, burst_level_control, s_axi_awvalid, s_axi_wvalid} = '0;
        {s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, bidx, nbytes} = '0;
        s_axi_wstrb = 4'hf;
        srst = 1'b1;
        repeat (16) @(posedge ref_clk);
        srst <= 1'b0;
        repeat (3) @(posedge ref_clk);
        // Reset values, then reserved bits held at zero
        for (int i = 0; i < 4; i++) begin
            rdr(addrs[i]);
            `CHK("reset value", {24'h0, rstv[i]}, rd)
            wr(addrs[i], 32'hffff_ffff);
            `CHK("write resp", RESP_OKAY, wresp)
            rdr(addrs[i]);
            `CHK("masked value", {24'h0, maskv[i]}, rd)
        end
        rdr(ADDR_STATUS);
        `CHK("status idle", 32'h01, rd)
        wr(8'h00, 32'h0000_00ff);
        `CHK("unmapped write resp", RESP_SLVERR, wresp)
        rdr(8'h00);
        `CHK("unmapped read", 32'h0, rd)
        `CHK("unmapped read resp", RESP_SLVERR, rresp)
        // Final byte truncation, LSB first, stop codes, guard from end of send
        wr(ADDR_GUARD_LOW, 32'h04);
        for (int lb = 0; lb < 8; lb++) begin
            wr(ADDR_FRAME_CTRL, 32'h08 | lb);
            wr(ADDR_GUARD_CTRL, lb);
            frame(2, 1'b0);
            nbits = 8 + ((lb == 0) ? 8 : lb);
            `CHK("bit count", nbits + lb, tag.bit_q.size())
            for (int i = 0; i < nbits; i++)
                `CHK("data bit", bytes[i / 8][i % 8], tag.bit_q[i])
            for (int i = nbits; i < nbits + lb; i++)
                `CHK("stop bit", 1'b1, tag.bit_q[i])
            if (lb > 0)
                `CHK("guard gap", 1'b1, tag.gap_tx inside {[942:960]})
        end
        // Guard from end of reception
        wr(ADDR_GUARD_CTRL, 32'h80);
        tag.reply_en = 1'b1;
        frame(1, 1'b0);
        repeat (30) @(posedge ref_clk); // Let the reply end arrive first
        frame(1, 1'b0);
        `CHK("rx guard gap", 1'b1, tag.gap_rx inside {[942:960]})
        tag.reply_en = 1'b0;
        // Half-bit units with the upper guard bits in use
        wr(ADDR_GUARD_CTRL, 32'h48);
        wr(ADDR_GUARD_LOW, 32'h02);
        frame(1, 1'b0);
        frame(1, 1'b0);
        `CHK("long guard gap", 1'b1, tag.gap_tx >= 1030 && tag.gap_tx <= 1032 + 2 * BC)
        // Grid alignment of frame starts, after the long guard has run out
        repeat (1100) @(posedge ref_clk);
        wr(ADDR_GUARD_CTRL, 32'h00);
        wr(ADDR_GUARD_LOW, 32'h01);
        wr(ADDR_FRAME_CTRL, 32'h18);
        frame(1, 1'b0);
        frame(1, 1'b0);
        `CHK("start spacing mod etu", 0, tag.spacing % BC)
        // Symbol pattern only, no payload
        wr(ADDR_FRAME_CTRL, 32'h00);
        frame(1, 1'b0);
        `CHK("symbol bits", 1, tag.bit_q.size())
        `CHK("symbol value", 1'b0, tag.bit_q[0])
        // Burst lengths and levels for every code but unused code 3
        wr(ADDR_GUARD_LOW, 32'h00);
        for (int i = 0; i < 7; i++) begin
            wr(ADDR_BURST_LEN, codes[i] << 4);
            burst_level_control <= i[0];
            frame(0, 1'b1);
            all_lvl = 1'b1;
            for (int k = 0; k < tag.bit_q.size(); k++) all_lvl &= (tag.bit_q[k] === i[0]);
            `CHK("burst bits", lens[i], tag.bit_q.size())
            `CHK("burst level", 1'b1, all_lvl)
        end
        finish_test();
    end
endmodule
`default_nettype wire
